// >>> pkg/lmc_consts.svh
`ifndef LMC_CONSTS_SVH
`define LMC_CONSTS_SVH
// Summary of operation
// R01: Slave station holds slave link enable ON
// R02: Ordinary link slave holds enable OFF
// R03: Port free flag driven by controller
// R04: Single cycle: last packet sets flags, stops
// R05: Restart needs abort, then run rising edge
// R06: Cyclic: restart first packet, flags stay OFF
// R07: Override word 55H plus station makes master
// R08: Station word shows current station number
// R09: Station word 55H defines station number
// R10: Record abnormal slave number, zero is normal
// R11: Record holds one; software clears to zero
// R12: Slave detected only when slave transmits
// R13: Master-only tables need separate supervision
// R14: Run edge seizes port or waits free
// R15: Pause or abort leaves link, frees port

// ****************************************
// Register offsets
// ****************************************
`define LMC_A_CTRL 8'h00
`define LMC_A_STAT 8'h04
`define LMC_A_TABLE 8'h08
`define LMC_A_OVR 8'h0C
`define LMC_A_STW 8'h10
`define LMC_A_FAULT 8'h14
`define LMC_A_IRQS 8'h18
`define LMC_A_IRQM 8'h1C

// ****************************************
// Fields and codes
// ****************************************
`define LMC_B_RUN 0
`define LMC_B_PAUSE 1
`define LMC_B_ABORT 2
`define LMC_B_SINGLE 3
`define LMC_B_TXMAP 5'h04
`define LMC_I_DONE 0
`define LMC_I_FAULT 1
`define LMC_I_SERR 2
`define LMC_MAGIC 8'h55
`define LMC_MASTER_STN 8'h01
`define LMC_STN_BASE 8'h02
`define LMC_RESP_OK 2'h0
`define LMC_RESP_ERR 2'h2

// ****************************************
// Timing
// ****************************************
`define LMC_RSP_TMO 8'h10
`define LMC_RSP_DLY 4'h2
`endif

// >>> pkg/lmc_pkg.sv
package lmc_pkg;
	typedef enum logic [3:0] {
		LMC_IDLE = 4'b0001,
		LMC_WAIT = 4'b0010,
		LMC_SEND = 4'b0100,
		LMC_STOP = 4'b1000
	} lmc_state_t;
	typedef enum logic [1:0] {
		LMC_S_IDLE = 2'b01,
		LMC_S_BUSY = 2'b10
	} lmc_stn_state_t;
	typedef logic [7:0] lmc_stn_t;
endpackage

// >>> pkg/lmc_link_if.sv
`timescale 1ns/1ps
interface lmc_link_if;
	logic req_valid;
	lmc_pkg::lmc_stn_t req_station;
	logic req_slave_tx;
	logic ack;
	logic ack_ok;
	logic slave_en;
	modport ctrl (
		output req_valid,
		output req_station,
		output req_slave_tx,
		input ack,
		input ack_ok,
		input slave_en
	);
	modport stn (
		input req_valid,
		input req_station,
		input req_slave_tx,
		output ack,
		output ack_ok,
		output slave_en
	);
endinterface

// >>> rtl/lmc_station.sv
`timescale 1ns/1ps
`include "lmc_consts.svh"
module lmc_station (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire logic I_CE,
	input wire lmc_pkg::lmc_stn_t I_STATION,
	input wire logic I_SLAVE_LINK_EN,
	input wire logic I_FAULT_INJECT,
	output logic [15:0] O_SERVED,
	lmc_link_if.stn link
);
	import lmc_pkg::*;

	lmc_stn_state_t state, next_state;
	logic [3:0] dly, next_dly;
	logic ack, next_ack;
	logic ack_ok, next_ack_ok;
	logic en, next_en;
	logic [15:0] served, next_served;

	assign link.ack = ack;
	assign link.ack_ok = ack_ok;
	assign link.slave_en = en;
	assign O_SERVED = served;

	always_comb begin
		next_state = state;
		next_dly = dly;
		next_ack = 1'b0;
		next_ack_ok = ack_ok;
		next_en = I_SLAVE_LINK_EN; // R01 R02
		next_served = served;
		case (state)
			LMC_S_IDLE: begin
				// Disabled slave stays silent; master sees a timeout
				if (link.req_valid && link.req_station == I_STATION && en) begin
					next_state = LMC_S_BUSY;
					next_dly = '0;
				end
			end
			LMC_S_BUSY: begin
				if (dly == `LMC_RSP_DLY) begin
					next_state = LMC_S_IDLE;
					next_ack = 1'b1;
					next_ack_ok = ~(link.req_slave_tx & I_FAULT_INJECT);
					next_served = served + 16'h0001;
				end else begin
					next_dly = dly + 4'h1;
				end
			end
			default: next_state = LMC_S_IDLE;
		endcase
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			state <= LMC_S_IDLE;
			dly <= '0;
			ack <= 1'b0;
			ack_ok <= 1'b0;
			en <= 1'b0;
			served <= '0;
		end else if (I_CE) begin
			state <= next_state;
			dly <= next_dly;
			ack <= next_ack;
			ack_ok <= next_ack_ok;
			en <= next_en;
			served <= next_served;
		end
	end
endmodule

// >>> rtl/lmc_ctrl.sv
`timescale 1ns/1ps
`include "lmc_consts.svh"
module lmc_ctrl (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire logic I_CE,
	input wire lmc_pkg::lmc_stn_t I_STATION_ID,
	input wire logic I_PORT_HELD,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic O_IRQ,
	output logic O_PORT_FREE,
	output logic O_CYCLE_DONE,
	lmc_link_if.ctrl link
);
	import lmc_pkg::*;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nv,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nv[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_magic(input logic [15:0] w);
		return w[15:8] == `LMC_MAGIC;
	endfunction

	// ****************************************
	// Station strap synchroniser
	// ****************************************
	lmc_stn_t stn_s1, stn_s2;
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			stn_s1 <= '0;
			stn_s2 <= '0;
		end else if (I_CE) begin
			stn_s1 <= I_STATION_ID;
			stn_s2 <= stn_s1;
		end
	end

	// ****************************************
	// Register file and AXI4-Lite slave
	// ****************************************
	logic [3:0] ctrl, next_ctrl;
	logic [19:0] table_w, next_table_w;
	logic [15:0] ovr, next_ovr, stw, next_stw, fault, next_fault;
	logic [2:0] irqs, next_irqs, irqm, next_irqm;
	logic irq, next_irq;
	logic aw_rdy, next_aw_rdy, w_rdy, next_w_rdy, aw_got, next_aw_got, w_got, next_w_got;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, ar_rdy, next_ar_rdy, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [31:0] wm;
	logic done_evt, fault_evt, serr_evt;
	lmc_stn_t fault_stn, own_stn;
	lmc_state_t state, next_state;
	logic port_free, next_port_free, cycle_done, next_cycle_done;

	assign own_stn = is_magic(stw) ? stw[7:0] : stn_s2; // R09
	assign O_AWREADY = aw_rdy;
	assign O_WREADY = w_rdy;
	assign O_BVALID = bvalid;
	assign O_BRESP = bresp;
	assign O_ARREADY = ar_rdy;
	assign O_RVALID = rvalid;
	assign O_RDATA = rdata;
	assign O_RRESP = rresp;
	assign O_IRQ = irq;

	always_comb begin
		next_ctrl = ctrl;
		next_table_w = table_w;
		next_ovr = ovr;
		next_stw = stw;
		next_fault = fault;
		next_irqs = irqs;
		next_irqm = irqm;
		next_aw_rdy = aw_rdy;
		next_w_rdy = w_rdy;
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_ar_rdy = ar_rdy;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		wm = '0;
		if (I_AWVALID && aw_rdy) begin
			next_aw_got = 1'b1;
			next_aw_rdy = 1'b0;
			next_aw_addr = I_AWADDR;
		end
		if (I_WVALID && w_rdy) begin
			next_w_got = 1'b1;
			next_w_rdy = 1'b0;
			next_w_data = I_WDATA;
			next_w_strb = I_WSTRB;
		end
		if (aw_got && w_got && !bvalid) begin
			next_bvalid = 1'b1;
			next_bresp = `LMC_RESP_OK;
			case (aw_addr)
				`LMC_A_CTRL: begin
					wm = wmerge({28'h000_0000, ctrl}, w_data, w_strb);
					next_ctrl = wm[3:0];
				end
				`LMC_A_TABLE: begin
					wm = wmerge({12'h000, table_w}, w_data, w_strb);
					next_table_w = wm[19:0];
				end
				`LMC_A_OVR: begin
					wm = wmerge({16'h0000, ovr}, w_data, w_strb);
					next_ovr = wm[15:0]; // R07
				end
				`LMC_A_STW: begin
					wm = wmerge({16'h0000, stw}, w_data, w_strb);
					next_stw = wm[15:0];
				end
				`LMC_A_FAULT: begin
					wm = wmerge({16'h0000, fault}, w_data, w_strb);
					next_fault = wm[15:0]; // R11
				end
				`LMC_A_IRQS: next_irqs = irqs & ~w_data[2:0];
				`LMC_A_IRQM: next_irqm = w_data[2:0];
				`LMC_A_STAT: next_bresp = `LMC_RESP_OK;
				default: next_bresp = `LMC_RESP_ERR;
			endcase
		end
		if (bvalid && I_BREADY) begin
			next_bvalid = 1'b0;
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_aw_rdy = 1'b1;
			next_w_rdy = 1'b1;
		end
		if (I_ARVALID && ar_rdy) begin
			next_ar_rdy = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `LMC_RESP_OK;
			case (I_ARADDR)
				`LMC_A_CTRL: next_rdata = {28'h000_0000, ctrl};
				`LMC_A_STAT: next_rdata = {27'h000_0000, link.slave_en, 1'b0,
					state == LMC_SEND, cycle_done, port_free}; // R03
				`LMC_A_TABLE: next_rdata = {12'h000, table_w};
				`LMC_A_OVR: next_rdata = {16'h0000, ovr};
				`LMC_A_STW: next_rdata = {16'h0000, stw[15:8], own_stn}; // R08 R09
				`LMC_A_FAULT: next_rdata = {16'h0000, fault};
				`LMC_A_IRQS: next_rdata = {29'h0000_0000, irqs};
				`LMC_A_IRQM: next_rdata = {29'h0000_0000, irqm};
				default: begin
					next_rdata = '0;
					next_rresp = `LMC_RESP_ERR;
				end
			endcase
		end
		if (rvalid && I_RREADY) begin
			next_rvalid = 1'b0;
			next_ar_rdy = 1'b1;
		end
		// Hardware events win over a same-cycle software clear
		if (fault_evt) begin
			next_fault = {8'h00, fault_stn}; // R10 R11
		end
		next_irqs[`LMC_I_DONE] = next_irqs[`LMC_I_DONE] | done_evt;
		next_irqs[`LMC_I_FAULT] = next_irqs[`LMC_I_FAULT] | fault_evt;
		next_irqs[`LMC_I_SERR] = next_irqs[`LMC_I_SERR] | serr_evt;
		next_irq = |(next_irqs & next_irqm);
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			ctrl <= '0;
			table_w <= '0;
			ovr <= '0;
			stw <= '0;
			fault <= '0;
			irqs <= '0;
			irqm <= '0;
			irq <= 1'b0;
			aw_rdy <= 1'b1;
			w_rdy <= 1'b1;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= `LMC_RESP_OK;
			ar_rdy <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `LMC_RESP_OK;
		end else if (I_CE) begin
			ctrl <= next_ctrl;
			table_w <= next_table_w;
			ovr <= next_ovr;
			stw <= next_stw;
			fault <= next_fault;
			irqs <= next_irqs;
			irqm <= next_irqm;
			irq <= next_irq;
			aw_rdy <= next_aw_rdy;
			w_rdy <= next_w_rdy;
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			ar_rdy <= next_ar_rdy;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// ****************************************
	// Link sequencer
	// ****************************************
	logic run_q, next_run_q, req_v, next_req_v, req_tx, next_req_tx;
	lmc_stn_t req_stn, next_req_stn;
	logic [3:0] pkt, next_pkt;
	logic [7:0] tmo, next_tmo;
	logic halt, run_rise, may_master, done_pkt;

	assign link.req_valid = req_v;
	assign link.req_station = req_stn;
	assign link.req_slave_tx = req_tx;
	assign O_PORT_FREE = port_free;
	assign O_CYCLE_DONE = cycle_done;
	assign halt = ctrl[`LMC_B_PAUSE] | ctrl[`LMC_B_ABORT];
	assign run_rise = ctrl[`LMC_B_RUN] & ~run_q;
	assign may_master = own_stn == `LMC_MASTER_STN
		|| (is_magic(ovr) && ovr[7:0] == own_stn); // R07
	assign done_pkt = link.ack || tmo == `LMC_RSP_TMO;
	assign fault_stn = req_stn;

	always_comb begin
		next_state = state;
		next_run_q = ctrl[`LMC_B_RUN];
		next_req_v = req_v;
		next_req_stn = req_stn;
		next_req_tx = req_tx;
		next_pkt = pkt;
		next_tmo = tmo;
		next_port_free = port_free;
		next_cycle_done = cycle_done;
		done_evt = 1'b0;
		fault_evt = 1'b0;
		serr_evt = 1'b0;
		case (state)
			LMC_IDLE: begin
				if (run_rise && !halt) begin // R14
					if (!may_master) begin
						serr_evt = 1'b1;
					end else if (I_PORT_HELD) begin
						next_state = LMC_WAIT;
					end else begin
						next_pkt = '0;
						next_state = LMC_SEND;
					end
				end
			end
			LMC_WAIT: begin
				if (halt) begin
					next_state = LMC_IDLE; // R15
				end else if (!I_PORT_HELD) begin
					next_pkt = '0;
					next_state = LMC_SEND; // R14
				end
			end
			LMC_SEND: begin
				next_tmo = tmo + 8'h01;
				if (halt) begin
					next_state = LMC_IDLE; // R15
				end else if (done_pkt) begin
					// Master-only packets prove nothing about the slave
					fault_evt = req_tx & ~(link.ack & link.ack_ok); // R12 R13
					next_pkt = pkt + 4'h1;
					if (pkt == table_w[3:0]) begin
						next_pkt = '0; // R06
						if (ctrl[`LMC_B_SINGLE]) begin
							next_state = LMC_STOP; // R04
							next_cycle_done = 1'b1;
							done_evt = 1'b1;
						end
					end
				end
			end
			LMC_STOP: begin
				if (ctrl[`LMC_B_ABORT]) begin
					next_state = LMC_IDLE; // R05
				end
			end
			default: next_state = LMC_IDLE;
		endcase
		next_port_free = next_state != LMC_SEND; // R03
		if (next_state == LMC_SEND) begin
			next_cycle_done = 1'b0;
		end
		if (next_state == LMC_SEND && (state != LMC_SEND || done_pkt)) begin
			next_req_v = 1'b1;
			next_req_stn = {4'h0, next_pkt} + `LMC_STN_BASE;
			// Five-bit index: packets 12 to 15 must not wrap onto the count field
			next_req_tx = table_w[`LMC_B_TXMAP + 5'(next_pkt)];
			next_tmo = '0;
		end else if (next_state != LMC_SEND) begin
			next_req_v = 1'b0;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			state <= LMC_IDLE;
			run_q <= 1'b0;
			req_v <= 1'b0;
			req_stn <= '0;
			req_tx <= 1'b0;
			pkt <= '0;
			tmo <= '0;
			port_free <= 1'b1;
			cycle_done <= 1'b0;
		end else if (I_CE) begin
			state <= next_state;
			run_q <= next_run_q;
			req_v <= next_req_v;
			req_stn <= next_req_stn;
			req_tx <= next_req_tx;
			pkt <= next_pkt;
			tmo <= next_tmo;
			port_free <= next_port_free;
			cycle_done <= next_cycle_done;
		end
	end
endmodule

// >>> tb/lmc_link_chk.sv
`timescale 1ns/1ps
module lmc_link_chk (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire logic req_valid,
	input wire lmc_pkg::lmc_stn_t req_station,
	input wire logic ack,
	input wire logic slave_en,
	input wire logic O_PORT_FREE,
	input wire logic O_CYCLE_DONE
);
	import lmc_pkg::*;
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (I_SYS_RST);
	// ****************************************
	// Link handshake
	// ****************************************
	sequence s_take;
		$rose(req_valid) && slave_en && req_station == 8'h02;
	endsequence
	sequence s_answer;
		##4 ack ##1 !ack;
	endsequence
	property p_ack_delay;
		s_take |-> s_answer;
	endproperty
	a_ack_delay: assert property (p_ack_delay) else $error("ack late or long");
	property p_ack_src;
		ack |-> $past(req_valid, 4) && $past(slave_en, 4);
	endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	property p_ack_pulse;
		ack |=> !ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	// ****************************************
	// Port and cycle flags
	// ****************************************
	property p_busy;
		req_valid |-> !O_PORT_FREE;
	endproperty
	a_busy: assert property (p_busy) else $error("port free while sending");
	property p_seize;
		$fell(O_PORT_FREE) |-> ##[0:1] req_valid;
	endproperty
	a_seize: assert property (p_seize) else $error("port taken without request");
	property p_free_rise;
		$rose(O_PORT_FREE) |-> !req_valid;
	endproperty
	a_free_rise: assert property (p_free_rise) else $error("port freed mid request");
	property p_done_hold;
		O_CYCLE_DONE |-> O_PORT_FREE && !req_valid;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("link runs after done");
	property p_done_cause;
		$rose(O_CYCLE_DONE) |-> $past(req_valid);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done without packet");
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "lmc_consts.svh"
module testbench;
	import lmc_pkg::*;
	logic clk = 0, rst = 1, held = 0, sen = 1, finj = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rd;
	logic awready, wready, bvalid, arready, rvalid, irq, pfree, cdone;
	logic [1:0] bresp, rresp;
	logic [15:0] served;
	int bad_count = 0, checks_done = 0;
	lmc_link_if lnk();
	lmc_ctrl lmc_ctrl_i (.I_CLOCK(clk), .I_SYS_RST(rst), .I_CE(1'b1),
		.I_STATION_ID(8'h01), .I_PORT_HELD(held), .I_AWADDR(awaddr),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rd), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.O_IRQ(irq), .O_PORT_FREE(pfree), .O_CYCLE_DONE(cdone), .link(lnk));
	lmc_station lmc_station_i (.I_CLOCK(clk), .I_SYS_RST(rst), .I_CE(1'b1),
		.I_STATION(8'h02), .I_SLAVE_LINK_EN(sen), .I_FAULT_INJECT(finj),
		.O_SERVED(served), .link(lnk));
	lmc_link_chk lmc_link_chk_i (.I_CLOCK(clk), .I_SYS_RST(rst),
		.req_valid(lnk.req_valid), .req_station(lnk.req_station), .ack(lnk.ack),
		.slave_en(lnk.slave_en), .O_PORT_FREE(pfree), .O_CYCLE_DONE(cdone));
	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask
	task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rd;
		r = rresp;
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", 32'h0000_0000, {30'h0000_0000, r});
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rdw(a, d, r);
		chk(nm, e, d & m);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ****************************************
	// Clock, watchdog, tests
	// ****************************************
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#200us;
		bad_count++;
		final_report;
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (4) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		rc("stat", `LMC_A_STAT, 32'h0000_0013, 32'h0000_0011);
		rc("fault", `LMC_A_FAULT, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("station", `LMC_A_STW, 32'hFFFF_FFFF, 32'h0000_0001);
		rdw(8'h40, d, r);
		chk("rresp", 32'h0000_0002, {30'h0000_0000, r});
		wr(8'h40, 32'h0000_0001, r);
		chk("bresp", 32'h0000_0002, {30'h0000_0000, r});
		$display("test registers done");
		w(`LMC_A_STW, 32'h0000_5507);
		rc("station", `LMC_A_STW, 32'h0000_FFFF, 32'h0000_5507);
		w(`LMC_A_CTRL, 32'h0000_0001);
		repeat (4) @(posedge clk);
		rc("irq", `LMC_A_IRQS, 32'h0000_0004, 32'h0000_0004);
		chk("free", 32'h1, pfree);
		w(`LMC_A_IRQS, 32'h0000_0004);
		$display("test master refusal done");
		w(`LMC_A_CTRL, 32'h0000_0000);
		w(`LMC_A_OVR, 32'h0000_5507);
		w(`LMC_A_TABLE, 32'h0000_0010);
		w(`LMC_A_IRQM, 32'h0000_0001);
		w(`LMC_A_CTRL, 32'h0000_0009);
		for (int i = 0; i < 100 && cdone !== 1'b1; i++) @(posedge clk);
		chk("done", 32'h1, cdone);
		chk("free", 32'h1, pfree);
		chk("served", 32'h1, served);
		chk("irq", 32'h1, irq);
		w(`LMC_A_IRQS, 32'h0000_0001);
		chk("irq", 32'h0, irq);
		$display("test single cycle done");
		w(`LMC_A_CTRL, 32'h0000_0004);
		w(`LMC_A_CTRL, 32'h0000_0000);
		w(`LMC_A_CTRL, 32'h0000_0001);
		repeat (60) @(posedge clk);
		chk("done", 32'h0, cdone);
		chk("free", 32'h0, pfree);
		chk("cycling", 32'h1, served > 16'h0004);
		$display("test cyclic done");
		finj <= 1;
		repeat (20) @(posedge clk);
		finj <= 0;
		repeat (10) @(posedge clk);
		rc("fault", `LMC_A_FAULT, 32'h0000_FFFF, 32'h0000_0002);
		rc("irq", `LMC_A_IRQS, 32'h0000_0002, 32'h0000_0002);
		w(`LMC_A_FAULT, 32'h0000_0000);
		rc("fault", `LMC_A_FAULT, 32'h0000_FFFF, 32'h0000_0000);
		$display("test fault record done");
		w(`LMC_A_CTRL, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk("free", 32'h1, pfree);
		w(`LMC_A_CTRL, 32'h0000_0000);
		held <= 1;
		w(`LMC_A_CTRL, 32'h0000_0001);
		repeat (5) @(posedge clk);
		chk("free", 32'h1, pfree);
		held <= 0;
		repeat (3) @(posedge clk);
		chk("free", 32'h0, pfree);
		sen <= 0;
		repeat (40) @(posedge clk);
		rc("peer", `LMC_A_STAT, 32'h0000_0010, 32'h0000_0000);
		rc("fault", `LMC_A_FAULT, 32'h0000_FFFF, 32'h0000_0002);
		w(`LMC_A_CTRL, 32'h0000_0004);
		repeat (2) @(posedge clk);
		chk("free", 32'h1, pfree);
		$display("test halt and wait done");
		w(`LMC_A_FAULT, 32'h0000_0000);
		w(`LMC_A_TABLE, 32'h0000_0000);
		w(`LMC_A_CTRL, 32'h0000_0000);
		w(`LMC_A_CTRL, 32'h0000_0001);
		repeat (40) @(posedge clk);
		rc("stat", `LMC_A_STAT, 32'h0000_0007, 32'h0000_0004);
		rc("fault", `LMC_A_FAULT, 32'h0000_FFFF, 32'h0000_0000);
		$display("test master only table done");
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk("free", 32'h1, pfree);
		chk("done", 32'h0, cdone);
		chk("irq", 32'h0, irq);
		rc("stat", `LMC_A_STAT, 32'h0000_0017, 32'h0000_0001);
		rc("station", `LMC_A_STW, 32'hFFFF_FFFF, 32'h0000_0001);
		rc("fault", `LMC_A_FAULT, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("test reset done");
		final_report;
	end
endmodule
